// *** dv/adcsc_ctrl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsc_ctrl_monitor
  import adcsc_pkg::*;
(
  input wire logic                   CORE_CLK_I,
  input wire logic                   RESET_I,
  input wire logic                   SELECT_N_I,
  input wire logic                   RESULT_VALID_I,
  input wire logic                   SERIAL_OUT_OE_O,
  input wire logic                   FRAME_SYNC_OUT_O,
  input wire logic                   CONVERSION_DONE_N_O,
  input wire logic                   TRACK_HOLD_O,
  input wire logic                   ANALOG_AWAKE_O,
  input wire logic [ADCSC_CMD_W-1:0] COMMAND_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  // ****************************************
  // Select driven state, command, done flag and frame sync checks, allowing sync lag
  // ****************************************
  chk_oe_off_idle: assert property (SELECT_N_I [*4] |-> !SERIAL_OUT_OE_O)
    else $error("output enable high while deselected");
  chk_oe_on_sel: assert property (!SELECT_N_I [*4] |-> SERIAL_OUT_OE_O)
    else $error("output enable low while selected");
  chk_awake_sel: assert property (!SELECT_N_I [*4] |-> ANALOG_AWAKE_O)
    else $error("analog asleep while selected");
  chk_sleep_idle: assert property (SELECT_N_I [*4] |-> !ANALOG_AWAKE_O)
    else $error("analog awake while deselected");
  chk_track_idle: assert property (SELECT_N_I [*4] |-> !TRACK_HOLD_O)
    else $error("hold kept after deselect");
  chk_cmd_frame: assert property (!SELECT_N_I [*5] |-> $stable(COMMAND_O))
    else $error("command changed inside a frame");
  chk_done_ext: assert property (!COMMAND_O[0] && !$past(COMMAND_O[0]) |-> CONVERSION_DONE_N_O)
    else $error("done flag low in external clock mode");
  chk_done_int: assert property (COMMAND_O[0] && $past(COMMAND_O[0]) && RESULT_VALID_I &&
    $past(RESULT_VALID_I) |-> !CONVERSION_DONE_N_O)
    else $error("done flag high with result ready");
  chk_fso_width: assert property ($rose(FRAME_SYNC_OUT_O) |-> FRAME_SYNC_OUT_O [*6] ##[1:2] !FRAME_SYNC_OUT_O)
    else $error("frame sync out not one link period");
  chk_fso_oe: assert property (FRAME_SYNC_OUT_O |-> SERIAL_OUT_OE_O)
    else $error("frame sync out without data enabled");
endmodule : adcsc_ctrl_monitor
bind adcsc_ctrl adcsc_ctrl_monitor i_mon (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .SELECT_N_I(SELECT_N_I),
  .RESULT_VALID_I(RESULT_VALID_I), .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O), .FRAME_SYNC_OUT_O(FRAME_SYNC_OUT_O),
  .CONVERSION_DONE_N_O(CONVERSION_DONE_N_O), .TRACK_HOLD_O(TRACK_HOLD_O), .ANALOG_AWAKE_O(ANALOG_AWAKE_O),
  .COMMAND_O(COMMAND_O));
`default_nettype wire

// *** dv/adcsc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsc_host #(
  parameter int HP = 32
) (
  output var logic sclk_o,
  output var logic sel_n_o,
  output var logic sdi_o,
  output var logic fsi_o,
  input wire logic dout_i,
  input wire logic th_i
);
  logic [63:0] rx;
  logic        hold_early;
  logic        hold_late;
  // Link clock stands still low between frames
  initial begin
    sclk_o = 1'b0;
    // Short select pulse at start so the link side sees a deselect edge
    sel_n_o = 1'b0;
    sdi_o = 1'b0;
    fsi_o = 1'b1;
    #1 sel_n_o = 1'b1;
  end
  task automatic frame(input logic [7:0] cmd, input int nclk, input logic dsp);
    rx = '0;
    fsi_o = !dsp;
    #20 sel_n_o = 1'b0;
    // Covers acquisition even in 8-bit width
    #400;
    for (int i = 0; i < nclk; i++) begin
      if (!dsp) sdi_o = (i < 8) ? cmd[7-i] : 1'b0;
      #(HP) sclk_o = 1'b1;
      // Sync is taken at the first falling edge; command bits follow it
      if (i > 0) fsi_o = 1'b1;
      if (dsp) sdi_o = (i >= 1 && i < 9) ? cmd[8-i] : 1'b0;
      #(HP-4) rx = {rx[62:0], dout_i};
      if (i == 1) hold_early = th_i;
      hold_late = th_i;
      #4 sclk_o = 1'b0;
    end
    #(HP) rx = {rx[62:0], dout_i};
    sel_n_o = 1'b1;
    sdi_o = !sdi_o;
    #300;
  endtask : frame
endmodule : adcsc_host
`default_nettype wire

// *** dv/test_adcsc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_adcsc_ctrl;
  import adcsc_pkg::*;
  logic                      clk = 1'b0;
  logic                      rst = 1'b0;
  logic                      wsel = 1'b1;
  logic                      rvalid = 1'b0;
  logic [ADCSC_RESULT_W-1:0] res = '0;
  logic                      sclk, sel_n, sdi, fsi, dout, oe, fso, done_n, th, awake, ref_on, buf_on;
  logic [ADCSC_CMD_W-1:0]    cmd_q;
  int                        fails = 0;
  int                        n_tests = 0;
  int                        cyc = 0;
  int                        fso_cnt = 0;
  always #5 clk = ~clk;
  adcsc_ctrl i_dut (.CORE_CLK_I(clk), .RESET_I(rst), .SCLK_I(sclk), .SELECT_N_I(sel_n), .SERIAL_IN_I(sdi),
    .FRAME_SYNC_IN_I(fsi), .WIDTH_SELECT_I(wsel), .RESULT_I(res), .RESULT_VALID_I(rvalid),
    .SERIAL_OUT_O(dout), .SERIAL_OUT_OE_O(oe), .FRAME_SYNC_OUT_O(fso), .CONVERSION_DONE_N_O(done_n),
    .TRACK_HOLD_O(th), .ANALOG_AWAKE_O(awake), .REF_ON_O(ref_on), .REF_BUF_ON_O(buf_on), .COMMAND_O(cmd_q));
  adcsc_host i_host (.sclk_o(sclk), .sel_n_o(sel_n), .sdi_o(sdi), .fsi_o(fsi), .dout_i(dout), .th_i(th));
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // Generous ceiling, the run needs about 1500 cycles
  always @(posedge clk) begin
    cyc++;
    if (fso) fso_cnt++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic spi_run(input logic [7:0] cmd, input logic w16, input logic [15:0] val);
    @(negedge clk);
    wsel = w16;
    res = val;
    fso_cnt = 0;
    i_host.frame(cmd, w16 ? 32 : 24, 1'b0);
    check("result", i_host.rx[16:1], val);
    check("pre_msb", w16 ? i_host.rx[32:17] : i_host.rx[24:17], 0);
    check("hold_early", i_host.hold_early, 0);
    check("hold_late", i_host.hold_late, 1);
    check("fso_spi", fso_cnt, 0);
    check("command", cmd_q, cmd);
    check("ref_on", ref_on, cmd[2:1] == 2'h0 || cmd[2:1] == 2'h2);
    check("buf_on", buf_on, cmd[2:1] == 2'h0);
    check("oe_idle", oe, 0);
    check("hold_idle", th, 0);
  endtask : spi_run
  task automatic test_reset();
    check("cmd_rst", cmd_q, ADCSC_CMD_RESET);
    check("done_rst", done_n, 1);
    check("awake_rst", awake, 0);
    check("ref_rst", {ref_on, buf_on}, 0);
  endtask : test_reset
  task automatic test_widths();
    spi_run(8'h00, 1'b1, 16'h8001);
    spi_run(8'h04, 1'b0, 16'hfffe);
    spi_run(8'h02, 1'b1, 16'h5a3c);
  endtask : test_widths
  task automatic test_dsp();
    @(negedge clk);
    res = 16'hc3a5;
    fso_cnt = 0;
    i_host.frame(8'h02, 34, 1'b1);
    check("fso_width", fso_cnt >= 6 && fso_cnt <= 7, 1);
    check("dsp_hold", i_host.hold_late, 1);
    check("dsp_awake", awake, 0);
    check("dsp_cmd", cmd_q, 8'h02);
  endtask : test_dsp
  task automatic test_done();
    spi_run(8'h07, 1'b1, 16'h0001);
    @(negedge clk);
    rvalid = 1'b1;
    repeat (4) @(negedge clk);
    check("done_int", done_n, 0);
    rvalid = 1'b0;
    repeat (4) @(negedge clk);
    check("done_idle", done_n, 1);
  endtask : test_done
  task automatic test_short_cmd();
    i_host.frame(8'hf8, 4, 1'b0);
    check("cmd_kept", cmd_q, 8'h07);
  endtask : test_short_cmd
  initial begin
    // Raised after time zero so the edge-reset command register sees it
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    test_reset();
    test_widths();
    test_dsp();
    test_done();
    test_short_cmd();
    finish_test();
  end
endmodule : test_adcsc_ctrl
`default_nettype wire

// *** rtl/adcsc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - DSP mode: a frame_sync_in pulse starts a conversion.
// - width_select low gives 8-bit transfers, high gives 16-bit.
// - DSP mode pulses frame_sync_out when the MSB is on serial_out.
// - External reference: shutdown while select_n high, running while low.
// - SPI mode: select_n falling wakes analog and enables command shifting.
// - SPI mode: serial clock edges start and pace acquisition and conversion.
// - serial_out low until MSB, at falling (SPI) or rising (DSP) edge 8 or 16.
// - Result is 16-bit unipolar, MSB first.
// - DSP mode only with external clock; serial clock drives conversion.
// - 16-bit mode acquisition lasts 11.5 serial clock cycles.
// - After acquisition, track_hold opens and holds for the conversion.
// - Internal reference: power-down behaviour chosen by command bits.
// - serial_out changes on falling (SPI) or rising (DSP); floats when deselected.
// - serial_in sampled on rising (SPI) or falling (DSP) edges.
// - conversion_done_n low on ready in internal clock, high in external.
// - Configured power-down entered on select_n rising edge.
module adcsc_ctrl
  import adcsc_pkg::*;
(
  input  wire logic                      CORE_CLK_I,
  input  wire logic                      RESET_I,
  input  wire logic                      SCLK_I,
  input  wire logic                      SELECT_N_I,
  input  wire logic                      SERIAL_IN_I,
  input  wire logic                      FRAME_SYNC_IN_I,
  input  wire logic                      WIDTH_SELECT_I,
  input  wire logic [ADCSC_RESULT_W-1:0] RESULT_I,
  input  wire logic                      RESULT_VALID_I,
  output logic                           SERIAL_OUT_O,
  output logic                           SERIAL_OUT_OE_O,
  output logic                           FRAME_SYNC_OUT_O,
  output logic                           CONVERSION_DONE_N_O,
  output logic                           TRACK_HOLD_O,
  output logic                           ANALOG_AWAKE_O,
  output logic                           REF_ON_O,
  output logic                           REF_BUF_ON_O,
  output logic [ADCSC_CMD_W-1:0]         COMMAND_O
);

  // ****************************************
  // Core-side status crossing from link side
  // ****************************************
  // Core domain only sees select_n and frame sync through synchronisers.
  // One shared synchroniser keeps the order of the two pin edges.
  logic [1:0] pin_sync;
  logic       sel_n_core;
  logic       fsin_core;
  logic       sel_n_core_d;
  logic       fsin_core_d;
  logic       dsp_mode_core;

  adcsc_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk_i (CORE_CLK_I),
    .d_i   ({SELECT_N_I, FRAME_SYNC_IN_I}),
    .q_o   (pin_sync)
  );

  assign sel_n_core = pin_sync[1];
  assign fsin_core  = pin_sync[0];

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      sel_n_core_d <= 1'b1;
      fsin_core_d  <= 1'b1;
    end else begin
      sel_n_core_d <= sel_n_core;
      fsin_core_d  <= fsin_core;
    end
  end

  // ****************************************
  // Link side: command and sequence
  // ****************************************
  // Low frame_sync_in level means a DSP is attached; host holds it high otherwise.
  logic                   dsp_mode;
  logic [4:0]             rise_cnt;
  logic [4:0]             fall_cnt;
  logic [ADCSC_CMD_W-1:0] cmd_shift;
  logic [ADCSC_CMD_W-1:0] cmd;
  logic [2:0]             cmd_bits;
  logic                   active;
  logic                   fs_armed;
  logic                   wide;
  logic [4:0]             msb_edge;
  logic [4:0]             acq_half;
  logic                   mode_dsp_next;

  assign mode_dsp_next = ~FRAME_SYNC_IN_I;
  assign wide          = WIDTH_SELECT_I;
  assign msb_edge      = wide ? ADCSC_MSB_EDGE_16 : ADCSC_MSB_EDGE_8;
  assign acq_half      = wide ? ADCSC_ACQ_HALF_16 : ADCSC_ACQ_HALF_8;

  // Frame latched at select_n fall; a DSP frame arms on frame_sync_in.
  always_ff @(negedge SELECT_N_I or posedge SELECT_N_I) begin
    if (SELECT_N_I) begin
      dsp_mode <= 1'b0;
    end else begin
      dsp_mode <= mode_dsp_next;
    end
  end

  // Rising-edge counter and serial_in sampling
  // Counters saturate, so extra clocks cannot wrap into a second result load.
  // Bit count wraps to zero after a full byte; that marks a complete command.
  always_ff @(posedge SCLK_I or posedge SELECT_N_I) begin
    if (SELECT_N_I) begin
      rise_cnt  <= 5'h00;
      cmd_shift <= 8'h00;
      cmd_bits  <= 3'h0;
    end else if (!(dsp_mode && !fs_armed)) begin
      if (rise_cnt != 5'h1f) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
      if (!dsp_mode && rise_cnt < 5'h08) begin
        cmd_shift <= {cmd_shift[6:0], SERIAL_IN_I};
        cmd_bits  <= cmd_bits + 3'h1;
      end
    end
  end

  // Falling-edge counter; DSP serial_in sampled here
  logic [ADCSC_CMD_W-1:0] cmd_shift_dsp;
  always_ff @(negedge SCLK_I or posedge SELECT_N_I) begin
    if (SELECT_N_I) begin
      fall_cnt      <= 5'h00;
      fs_armed      <= 1'b0;
      cmd_shift_dsp <= 8'h00;
    end else begin
      if (dsp_mode && !FRAME_SYNC_IN_I) begin
        fs_armed <= 1'b1;
      end
      if (!dsp_mode || fs_armed) begin
        if (fall_cnt != 5'h1f) begin
          fall_cnt <= fall_cnt + 5'h01;
        end
        if (dsp_mode && fall_cnt < 5'h08) begin
          cmd_shift_dsp <= {cmd_shift_dsp[6:0], SERIAL_IN_I};
        end
      end
    end
  end

  // Command word kept across frames; only updated on a full byte
  always_ff @(posedge SELECT_N_I or posedge RESET_I) begin
    if (RESET_I) begin
      cmd <= ADCSC_CMD_RESET;
    end else if (dsp_mode && fall_cnt >= 5'h08) begin
      cmd <= cmd_shift_dsp;
    end else if (!dsp_mode && cmd_bits == 3'h0 && rise_cnt >= 5'h08) begin
      cmd <= cmd_shift;
    end
  end

  assign active = ~SELECT_N_I;

  // ****************************************
  // Track/hold and result output
  // ****************************************
  // Half-period count: rising edges plus falling edges seen in frame.
  logic [5:0] half_cnt;
  logic       holding;
  logic       out_launch;
  logic       load_result;
  logic       shift_bit;
  logic       msb_bit;
  logic       edge_now;

  // A slow host stretches acquisition, since hold waits on link edges only.
  assign half_cnt = {1'b0, rise_cnt} + {1'b0, fall_cnt};
  assign holding  = active && (half_cnt[4:0] >= acq_half || half_cnt[5]);

  // Launch clock is falling edge in SPI, rising in DSP
  // Number of the launching edge; the counter still holds the edges before it
  function automatic logic [5:0] adcsc_edge_number(input logic       dsp,
                                                   input logic [4:0] rises,
                                                   input logic [4:0] falls);
    logic [4:0] seen;
    seen = dsp ? rises : falls;
    return {1'b0, seen} + 6'h01;
  endfunction : adcsc_edge_number

  logic [5:0] launch_num;
  logic [5:0] msb_num;

  assign launch_num  = adcsc_edge_number(dsp_mode, rise_cnt, fall_cnt);
  assign msb_num     = {1'b0, msb_edge};
  assign edge_now    = dsp_mode ? SCLK_I : ~SCLK_I;
  assign load_result = launch_num == msb_num;
  assign shift_bit   = launch_num > msb_num;

  logic out_clk;
  assign out_clk = edge_now;

  adcsc_shift #(
    .WIDTH (ADCSC_RESULT_W)
  ) u_shift (
    .clk_i   (out_clk),
    .load_i  (load_result),
    // MSB leaves directly at the load edge, so the register starts one bit down
    .data_i  ({RESULT_I[ADCSC_RESULT_W-2:0], 1'b0}),
    .shift_i (shift_bit),
    .msb_o   (msb_bit)
  );

  logic out_data;
  logic out_en;
  logic fs_out;
  always_ff @(posedge out_clk or posedge SELECT_N_I) begin
    if (SELECT_N_I) begin
      out_data <= 1'b0;
      fs_out   <= 1'b0;
    end else begin
      // Low until the MSB edge, then result bits
      out_data <= (launch_num >= msb_num)
                  ? (load_result ? RESULT_I[ADCSC_RESULT_W-1] : msb_bit)
                  : 1'b0;
      fs_out   <= dsp_mode && load_result;
    end
  end
  assign out_en = active;

  // ****************************************
  // Power state, core domain
  // ****************************************
  logic       sel_rise;
  logic       sel_fall;
  adcsc_pwr_t pwr;
  logic [1:0] pd_sel;

  assign sel_rise = sel_n_core && !sel_n_core_d;
  assign sel_fall = !sel_n_core && sel_n_core_d;
  assign pd_sel   = cmd[ADCSC_CMD_PD_LSB +: 2];

  // Core copy of the command, taken once select has settled high; the link
  // register only changes on the select rise, so it is quiet by then.
  logic [ADCSC_CMD_W-1:0] cmd_core;
  logic [1:0]             pd_core;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      cmd_core <= ADCSC_CMD_RESET;
    end else if (sel_rise) begin
      cmd_core <= cmd;
    end
  end

  assign pd_core = cmd_core[ADCSC_CMD_PD_LSB +: 2];

  // Standby state chosen by the two power-down bits at deselect
  function automatic adcsc_pwr_t adcsc_pd_state(input logic [1:0] pd);
    adcsc_pwr_t state;
    case (pd)
      2'h0:    state = ADCSC_PWR_ON;
      2'h2:    state = ADCSC_PWR_REF_ON;
      default: state = ADCSC_PWR_ALL_OFF;
    endcase
    return state;
  endfunction : adcsc_pd_state

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      pwr <= ADCSC_PWR_ALL_OFF;
    end else if (sel_rise) begin
      pwr <= adcsc_pd_state(pd_sel);
    end else if (sel_fall || (dsp_mode_core && fsin_core_d && !fsin_core)) begin
      pwr <= ADCSC_PWR_ON;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      dsp_mode_core <= 1'b0;
    end else if (sel_fall) begin
      dsp_mode_core <= !fsin_core;
    end
  end

  // ****************************************
  // Registered top-level outputs
  // ****************************************
  // Link outputs are re-timed in core domain; glitch-free but lag up to 30 ns.
  // Enable rides the same synchroniser as the data, so both move together.
  logic [3:0] link_sync;
  adcsc_sync #(
    .WIDTH (4)
  ) u_link_sync (
    .clk_i (CORE_CLK_I),
    .d_i   ({out_en, holding, out_data, fs_out}),
    .q_o   (link_sync)
  );

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      SERIAL_OUT_O     <= 1'b0;
      SERIAL_OUT_OE_O  <= 1'b0;
      FRAME_SYNC_OUT_O <= 1'b0;
      TRACK_HOLD_O     <= 1'b0;
    end else begin
      SERIAL_OUT_O     <= link_sync[1];
      SERIAL_OUT_OE_O  <= link_sync[3];
      FRAME_SYNC_OUT_O <= link_sync[0];
      TRACK_HOLD_O     <= link_sync[2];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      CONVERSION_DONE_N_O <= 1'b1;
      ANALOG_AWAKE_O      <= 1'b0;
      REF_ON_O            <= 1'b0;
      REF_BUF_ON_O        <= 1'b0;
      COMMAND_O           <= ADCSC_CMD_RESET;
    end else begin
      // Internal clock mode: done low when core reports result
      if (cmd_core[ADCSC_CMD_CLK_BIT] && !dsp_mode_core) begin
        CONVERSION_DONE_N_O <= !RESULT_VALID_I;
      end else begin
        CONVERSION_DONE_N_O <= 1'b1;
      end
      ANALOG_AWAKE_O <= !sel_n_core;
      REF_ON_O       <= pwr != ADCSC_PWR_ALL_OFF && pd_core != ADCSC_PD_EXTERNAL;
      REF_BUF_ON_O   <= pwr == ADCSC_PWR_ON && pd_core != ADCSC_PD_EXTERNAL;
      COMMAND_O      <= cmd_core;
    end
  end

endmodule : adcsc_ctrl
`default_nettype wire

// *** rtl/adcsc_pkg.sv ***
package adcsc_pkg;

  // ****************************************
  // Transfer geometry
  // ****************************************
  localparam int          ADCSC_RESULT_W      = 16;
  localparam int          ADCSC_CMD_W         = 8;
  localparam logic [4:0]  ADCSC_MSB_EDGE_8    = 5'h08;
  localparam logic [4:0]  ADCSC_MSB_EDGE_16   = 5'h10;
  // Acquisition of 11.5 (16-bit) or 7.5 (8-bit) link clocks, counted in half periods
  localparam logic [4:0]  ADCSC_ACQ_HALF_16   = 5'h17;
  localparam logic [4:0]  ADCSC_ACQ_HALF_8    = 5'h0f;
  localparam logic [4:0]  ADCSC_CONV_CLOCKS   = 5'h10;

  // ****************************************
  // Command byte fields
  // ****************************************
  localparam int          ADCSC_CMD_CLK_BIT   = 0;
  localparam int          ADCSC_CMD_PD_LSB    = 1;
  localparam logic [7:0]  ADCSC_CMD_RESET     = 8'h06;
  localparam logic [1:0]  ADCSC_PD_EXTERNAL   = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          ADCSC_CORE_PERIOD_NS = 10;
  localparam int          ADCSC_ACQ_MIN_NS     = 729;
  localparam int          ADCSC_ACQ_MIN_CYC    =
    (ADCSC_ACQ_MIN_NS + ADCSC_CORE_PERIOD_NS - 1) / ADCSC_CORE_PERIOD_NS;

  typedef enum logic [1:0] {
    ADCSC_PWR_ON,
    ADCSC_PWR_REF_ON,
    ADCSC_PWR_ALL_OFF
  } adcsc_pwr_t;

endpackage : adcsc_pkg

// *** rtl/adcsc_shift.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsc_shift
  import adcsc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             shift_i,
  output logic                  msb_o
);
  logic [WIDTH-1:0] sr;

  // Result leaves MSB first
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      sr <= data_i;
    end else if (shift_i) begin
      sr <= {sr[WIDTH-2:0], 1'b0};
    end
  end

  assign msb_o = sr[WIDTH-1];
endmodule : adcsc_shift
`default_nettype wire

// *** rtl/adcsc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsc_sync
  import adcsc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o  <= meta;
  end
endmodule : adcsc_sync
`default_nettype wire
